// ==== hw/nsc_pkg.sv ====
package nsc_pkg;
    // Command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_PROG = 8'h10;
    localparam logic [7:0] CMD_MPROG = 8'h11;
    localparam logic [7:0] CMD_CPROG = 8'h15;
    localparam logic [7:0] CMD_CREAD = 8'h31;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS2 = 8'h71;
    localparam logic [7:0] CMD_SDIN = 8'h80;
    localparam logic [7:0] CMD_COLCHG = 8'h85;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    // Status byte bit positions
    localparam int ST_FAIL = 0;
    localparam int ST_FAIL_PREV = 1;
    localparam int ST_PB_RDY = 5;
    localparam int ST_DC_RDY = 6;
    localparam int ST_NOT_WP = 7;
    localparam logic [7:0] ST_ZERO_MASK = 8'h1C;
    // District field of fifth ID byte
    localparam int ID_DIST_LSB = 2;
    // Host limits
    localparam int PART_PROG_MAX = 4;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int BLOCKS = 2048;
    localparam int VALID_BLOCKS_MIN = 2008;
    // Strobe timing in cycles
    localparam int STROBE_CYC = 2;
    // User-side request
    typedef struct packed {
        logic [7:0] code;
        logic is_cmd;
        logic is_read;
        logic [15:0] page;
    } nsc_req_t;
    // Answer to the user
    typedef struct packed {
        logic [7:0] data;
        logic fail;
        logic fail_prev;
        logic pb_rdy;
        logic dc_rdy;
        logic not_wp;
        logic valid;
        logic [3:0] districts;
    } nsc_ans_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SETUP = 3'b001,
        S_STROBE = 3'b010,
        S_HOLD = 3'b011,
        S_DONE = 3'b100
    } nsc_state_t;
endpackage

// ==== hw/nsc_host.sv ====
`timescale 1ns/1ps
// Operation
// RL1: Send 70h, read status per strobe
// RL2: Bit one is program/erase pass-fail
// RL3: Cache program: bit one valid when PB ready
// RL4: Cache program: bit two valid when DC ready
// RL5: Bit six page buffer ready; 3-5 zero
// RL6: Bit seven data cache ready
// RL7: Bit eight high means not protected
// RL8: Trust pass-fail only when ready after program
// RL9: Bit six equals seven unless 15h/31h
// RL10: Status mode held until 00h issued; host clears its status mode on any command other than 70h/71h
// RL11: FFh halts any running operation
// RL12: Reset in cache program may abort two
// RL13: Power-up busy: only FFh or 70h
// RL14: Never send undefined command codes
// RL15: While busy only 70h, 71h, FFh
// RL16: After 80h only 85h,10h,11h,15h,FFh
// RL17: Program pages in ascending order
// RL18: Write-protect low aborts program/erase
// RL19: Sixth address cycle is ignored
// RL20: At most four partial programs per page
// RL21: Never erase bad blocks
// RL22: District field 00/01/10/11 means 1/2/4/8
// RL23: Status refreshed on every read strobe
module nsc_host
    import nsc_pkg::*;
#(
    parameter int PAGE_W = 16
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire nsc_pkg::nsc_req_t REQ,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    output logic REQ_REFUSED,
    output nsc_pkg::nsc_ans_t ANS,
    output logic CLE,
    output logic ALE,
    output logic CE_N,
    output logic WE_N,
    output logic READ_STROBE_N,
    output logic WP_N,
    output logic [7:0] IO_OUT,
    output logic IO_OE,
    input wire logic [7:0] IO_IN,
    input wire logic READY_BUSY_N,
    input wire logic WP_ENABLE
);
    import nsc_pkg::*;

    nsc_state_t state_reg; // Sequencer state
    nsc_req_t req_reg; // Request in flight
    logic [1:0] cnt_reg; // Strobe phase counter
    logic after_sdin_reg; // 80h seen, program open
    logic status_mode_reg; // Device in status mode
    logic [7:0] last_cmd_reg; // Command before status
    logic [7:0] prev_cmd_reg; // Command before last status
    logic [PAGE_W-1:0] last_page_reg; // Last programmed page
    logic [2:0] part_cnt_reg; // Partial programs on page
    logic boot_reg; // Power-up busy window not yet over
    logic prev_is_prog; // Status read follows a program
    logic allowed; // Command may be sent now
    logic known; // Command in defined set

    // Defined command set check; no erase code, so no bad block is erased
    always_comb begin
        known = (REQ.code == CMD_READ) || (REQ.code == CMD_PROG) ||
            (REQ.code == CMD_MPROG) || (REQ.code == CMD_CPROG) ||
            (REQ.code == CMD_CREAD) || (REQ.code == CMD_STATUS) ||
            (REQ.code == CMD_STATUS2) || (REQ.code == CMD_SDIN) ||
            (REQ.code == CMD_COLCHG) || (REQ.code == CMD_RESET); // RL14 RL21
    end

    // Admission of a request
    always_comb begin
        allowed = 1'b1;
        if (REQ.is_cmd && !known) begin
            allowed = 1'b0; // RL14
        end else if (REQ.is_cmd && boot_reg && !READY_BUSY_N &&
            REQ.code == CMD_STATUS2) begin
            allowed = 1'b0; // RL13
        end else if (REQ.is_cmd && !READY_BUSY_N &&
            REQ.code != CMD_STATUS && REQ.code != CMD_STATUS2 &&
            REQ.code != CMD_RESET) begin
            allowed = 1'b0; // RL13 RL15
        end else if (REQ.is_cmd && after_sdin_reg &&
            REQ.code != CMD_COLCHG && REQ.code != CMD_PROG &&
            REQ.code != CMD_MPROG && REQ.code != CMD_CPROG &&
            REQ.code != CMD_RESET) begin
            allowed = 1'b0; // RL16
        end else if (REQ.is_cmd && REQ.code == CMD_SDIN &&
            REQ.page[PAGE_W-1:0] < last_page_reg &&
            last_page_reg != '0) begin
            allowed = 1'b0; // RL17
        end else if (REQ.is_cmd && REQ.code == CMD_SDIN &&
            REQ.page[PAGE_W-1:0] == last_page_reg &&
            part_cnt_reg >= 3'(PART_PROG_MAX)) begin
            allowed = 1'b0; // RL20
        end else if (REQ.is_cmd && REQ.code == CMD_SDIN && !WP_ENABLE) begin
            allowed = 1'b0; // RL18
        end
    end

    // Sequencer driving the pin strobes
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg <= S_IDLE;
            req_reg <= '0;
            cnt_reg <= 2'h0;
            REQ_READY <= 1'b0;
            REQ_REFUSED <= 1'b0;
            CLE <= 1'b0;
            ALE <= 1'b0;
            CE_N <= 1'b1;
            WE_N <= 1'b1;
            READ_STROBE_N <= 1'b1;
            IO_OUT <= 8'h00;
            IO_OE <= 1'b0;
        end else begin
            REQ_REFUSED <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    REQ_READY <= 1'b1;
                    if (REQ_VALID && REQ_READY) begin
                        REQ_READY <= 1'b0;
                        if (allowed) begin
                            req_reg <= REQ;
                            CE_N <= 1'b0;
                            CLE <= REQ.is_cmd;
                            ALE <= !REQ.is_cmd && !REQ.is_read;
                            IO_OUT <= REQ.code;
                            IO_OE <= !REQ.is_read;
                            state_reg <= S_SETUP;
                        end else begin
                            REQ_REFUSED <= 1'b1;
                        end
                    end
                end
                S_SETUP: begin
                    cnt_reg <= 2'h0;
                    if (req_reg.is_read) begin
                        READ_STROBE_N <= 1'b0; // RL1 RL23
                    end else begin
                        WE_N <= 1'b0;
                    end
                    state_reg <= S_STROBE;
                end
                S_STROBE: begin
                    cnt_reg <= cnt_reg + 2'h1;
                    if (cnt_reg == 2'(STROBE_CYC - 1)) begin
                        WE_N <= 1'b1;
                        READ_STROBE_N <= 1'b1;
                        state_reg <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    CLE <= 1'b0;
                    ALE <= 1'b0;
                    IO_OE <= 1'b0;
                    state_reg <= S_DONE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Track command history and program bookkeeping
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            after_sdin_reg <= 1'b0;
            status_mode_reg <= 1'b0;
            last_cmd_reg <= CMD_RESET;
            prev_cmd_reg <= CMD_RESET;
            last_page_reg <= '0;
            part_cnt_reg <= 3'h0;
        end else if (state_reg == S_HOLD && req_reg.is_cmd) begin
            if (req_reg.code == CMD_STATUS || req_reg.code == CMD_STATUS2) begin
                status_mode_reg <= 1'b1; // RL1
                prev_cmd_reg <= last_cmd_reg;
            end else if (req_reg.code == CMD_READ) begin
                status_mode_reg <= 1'b0; // RL10
            end else if (req_reg.code == CMD_RESET) begin
                status_mode_reg <= 1'b0; // RL11 RL12
                after_sdin_reg <= 1'b0;
            end else begin
                status_mode_reg <= 1'b0;
            end
            if (req_reg.code != CMD_STATUS && req_reg.code != CMD_STATUS2) begin
                last_cmd_reg <= req_reg.code;
            end
            if (req_reg.code == CMD_SDIN) begin
                after_sdin_reg <= 1'b1;
                if (req_reg.page[PAGE_W-1:0] == last_page_reg) begin
                    part_cnt_reg <= part_cnt_reg + 3'h1; // RL20
                end else begin
                    part_cnt_reg <= 3'h1;
                end
                last_page_reg <= req_reg.page[PAGE_W-1:0]; // RL17
            end else if (req_reg.code == CMD_PROG ||
                req_reg.code == CMD_MPROG || req_reg.code == CMD_CPROG) begin
                after_sdin_reg <= 1'b0;
            end else if (req_reg.code != CMD_COLCHG) begin
                after_sdin_reg <= 1'b0; // RL16
            end
        end
    end

    // Capture read byte and decode status fields
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ANS <= '0;
        end else begin
            ANS.valid <= 1'b0;
            if (state_reg == S_STROBE && req_reg.is_read &&
                cnt_reg == 2'(STROBE_CYC - 1)) begin
                ANS.data <= IO_IN;
                ANS.valid <= 1'b1;
                ANS.pb_rdy <= IO_IN[ST_PB_RDY]; // RL5
                ANS.dc_rdy <= IO_IN[ST_DC_RDY]; // RL6
                ANS.not_wp <= IO_IN[ST_NOT_WP]; // RL7
                ANS.fail <= status_mode_reg && prev_is_prog &&
                    IO_IN[ST_PB_RDY] && IO_IN[ST_FAIL]; // RL2 RL3 RL8
                ANS.fail_prev <= status_mode_reg &&
                    prev_cmd_reg == CMD_CPROG && IO_IN[ST_DC_RDY] &&
                    IO_IN[ST_FAIL_PREV]; // RL4 RL8
                ANS.districts <= 4'h1 << IO_IN[ID_DIST_LSB +: 2]; // RL22
            end
        end
    end

    // Write protect pin follows the user enable
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            WP_N <= 1'b0;
        end else begin
            WP_N <= WP_ENABLE; // RL18
        end
    end

    // Power-up busy window ends at the first ready seen
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            boot_reg <= 1'b1;
        end else if (READY_BUSY_N) begin
            boot_reg <= 1'b0; // RL13
        end
    end

    // Pass-fail bits only mean something after a program
    always_comb begin
        prev_is_prog = (prev_cmd_reg == CMD_PROG) ||
            (prev_cmd_reg == CMD_MPROG) ||
            (prev_cmd_reg == CMD_CPROG); // RL8
    end
endmodule

// ==== test/nsc_checker.sv ====
`timescale 1ns/1ps
module nsc_checker
    import nsc_pkg::*;
#(
    parameter int PAGE_W = 16
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire nsc_pkg::nsc_req_t REQ,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic REQ_REFUSED,
    input wire nsc_pkg::nsc_ans_t ANS,
    input wire logic CLE,
    input wire logic ALE,
    input wire logic WE_N,
    input wire logic READ_STROBE_N,
    input wire logic IO_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Read request taken
    sequence s_rd; REQ_VALID && REQ_READY && REQ.is_read; endsequence
    // Command taken and not refused
    sequence s_cmd;
        REQ_VALID && REQ_READY && REQ.is_cmd && !REQ.is_read ##1 !REQ_REFUSED;
    endsequence
    property p_ref; REQ_REFUSED |-> $past(REQ_VALID && REQ_READY); endproperty
    a_ref: assert property (p_ref) else $error("stray refusal");
    property p_ans; s_rd |-> ##4 ANS.valid; endproperty
    a_ans: assert property (p_ans) else $error("late answer");
    property p_pulse; ANS.valid |=> !ANS.valid; endproperty
    a_pulse: assert property (p_pulse) else $error("long valid");
    property p_one; REQ_VALID && REQ_READY |=> !REQ_READY; endproperty
    a_one: assert property (p_one) else $error("ready in transfer");
    property p_cmd; s_cmd |-> ##[0:2] (!WE_N && CLE); endproperty
    a_cmd: assert property (p_cmd) else $error("no command strobe");
    property p_rds; s_rd |-> ##[1:3] (!READ_STROBE_N && !IO_OE); endproperty
    a_rds: assert property (p_rds) else $error("no read strobe");
    property p_dist; ANS.valid |-> ANS.districts == (4'h1 << ANS.data[3:2]);
    endproperty
    a_dist: assert property (p_dist) else $error("bad districts");
    // Address byte taken and not refused
    sequence s_adr;
        REQ_VALID && REQ_READY && !REQ.is_cmd && !REQ.is_read
            ##1 !REQ_REFUSED;
    endsequence
    property p_adr; s_adr |-> ##[0:2] (!WE_N && ALE && !CLE); endproperty
    a_adr: assert property (p_adr) else $error("no address strobe");
    property p_fail; ANS.valid && !ANS.pb_rdy |-> !ANS.fail; endproperty
    a_fail: assert property (p_fail) else $error("fail while busy");
    property p_prev; ANS.valid && !ANS.dc_rdy |-> !ANS.fail_prev; endproperty
    a_prev: assert property (p_prev) else $error("prev while busy");
endmodule
bind nsc_host nsc_checker #(.PAGE_W(PAGE_W)) u_chk (
    .CLK(CLK), .RSTN(RSTN), .REQ(REQ), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_REFUSED(REQ_REFUSED), .ANS(ANS),
    .CLE(CLE), .ALE(ALE), .WE_N(WE_N), .READ_STROBE_N(READ_STROBE_N),
    .IO_OE(IO_OE)
);

// ==== test/nsc_flash_model.sv ====
`timescale 1ns/1ps
module nsc_flash_model
    import nsc_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CLE,
    input wire logic WE_N,
    input wire logic READ_STROBE_N,
    input wire logic WP_N,
    input wire logic [7:0] IO_OUT,
    output logic [7:0] IO_IN,
    output logic READY_BUSY_N
);
    logic stat_reg; // Status mode
    logic fail_reg; // Last program outcome
    logic [7:0] busy_reg; // Busy countdown
    logic we_d, rs_d; // Strobe history
    logic [7:0] st, val_reg; // Live status, last byte shown
    // Status byte: bits 2-4 stay zero
    always_comb begin
        st = 8'h00;
        st[ST_FAIL] = fail_reg;
        st[ST_FAIL_PREV] = fail_reg;
        st[ST_DC_RDY] = (busy_reg == 8'h00);
        st[ST_PB_RDY] = st[ST_DC_RDY];
        st[ST_NOT_WP] = WP_N;
    end
    // Ready pin driven high once the busy countdown reaches zero
    assign READY_BUSY_N = (busy_reg == 8'h00);
    // Bus driven during read strobe and one hold cycle, else scrambled
    assign IO_IN = (!READ_STROBE_N || !rs_d) ?
        (stat_reg ? st : 8'h0D) : ~val_reg;
    // Command latch on write strobe rising edge
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            busy_reg <= 8'h28;
            stat_reg <= 1'b0;
            fail_reg <= 1'b0;
            we_d <= 1'b1;
            rs_d <= 1'b1;
            val_reg <= 8'h00;
        end else begin
            we_d <= WE_N;
            rs_d <= READ_STROBE_N;
            if (busy_reg != 8'h00) busy_reg <= busy_reg - 8'h01;
            if (!READ_STROBE_N) val_reg <= IO_IN;
            if (WE_N && !we_d && CLE) begin
                if (IO_OUT == CMD_STATUS) stat_reg <= 1'b1;
                if (IO_OUT == CMD_READ) stat_reg <= 1'b0;
                if ((IO_OUT == CMD_PROG || IO_OUT == CMD_CPROG) &&
                    WP_N) begin
                    busy_reg <= 8'h30;
                    fail_reg <= 1'b1;
                end
                if (IO_OUT == CMD_RESET) begin
                    busy_reg <= 8'h08;
                    fail_reg <= 1'b0;
                end
            end
        end
    end
endmodule

// ==== test/nsc_host_test.sv ====
`timescale 1ns/1ps
module nsc_host_test;
    import nsc_pkg::*;
    logic clk, rstn, req_valid, wp_enable, ready, refused, rb_n;
    logic cle, we_n, rs_n, wp_n, ce_n;
    logic [7:0] io_out, io_in;
    nsc_req_t req;
    nsc_ans_t ans, a;
    int n_mismatch, n_compared, k;
    nsc_host DUT (.CLK(clk), .RSTN(rstn), .REQ(req), .REQ_VALID(req_valid),
        .REQ_READY(ready), .REQ_REFUSED(refused), .ANS(ans), .CLE(cle),
        .ALE(), .CE_N(ce_n), .WE_N(we_n), .READ_STROBE_N(rs_n), .WP_N(wp_n),
        .IO_OUT(io_out), .IO_OE(), .IO_IN(io_in), .READY_BUSY_N(rb_n),
        .WP_ENABLE(wp_enable));
    nsc_flash_model u_flash (.CLK(clk), .RSTN(rstn), .CLE(cle), .WE_N(we_n),
        .READ_STROBE_N(rs_n), .WP_N(wp_n), .IO_OUT(io_out), .IO_IN(io_in),
        .READY_BUSY_N(rb_n));
    // Final verdict
    task automatic end_sim;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Compare one value
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Issue one byte cycle once idle
    task automatic go(input logic [7:0] c, input logic cmd, input logic rd,
                      input logic [15:0] pg);
        for (int i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clk);
        cmp(ready, 1'b1);
        req = '{code: c, is_cmd: cmd, is_read: rd, page: pg};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    // Command with expected refusal flag
    task automatic send(input logic [7:0] c, input logic [15:0] pg,
                        input logic rf);
        go(c, 1'b1, 1'b0, pg);
        cmp(refused, rf);
    endtask
    // Read cycle, answer captured in a
    task automatic rd;
        go(8'h00, 1'b0, 1'b1, 16'h0000);
        for (int i = 0; i < 8 && ans.valid !== 1'b1; i++) @(negedge clk);
        a = ans;
        cmp(a.valid, 1'b1);
    endtask
    // Wait for the byte cycle to end, so busy has started, then for ready
    task automatic wait_rdy;
        for (int i = 0; i < 10 && ready !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 200 && rb_n !== 1'b1; i++) @(negedge clk);
        cmp(rb_n, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        wp_enable = 1'b1;
        req = '0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        send(CMD_STATUS2, 16'h0000, 1'b1);
        send(CMD_STATUS, 16'h0000, 1'b0);
        cmp(ce_n, 1'b0);
        rd();
        cmp(a.pb_rdy, 1'b0);
        cmp(a.not_wp, 1'b1);
        cmp(a.data & ST_ZERO_MASK, 8'h00);
        send(CMD_SDIN, 16'h0005, 1'b1);
        wait_rdy();
        send(8'h42, 16'h0000, 1'b1);
        send(CMD_SDIN, 16'h0005, 1'b0);
        for (k = 0; k < 6; k++) begin
            go(8'h05, 1'b0, 1'b0, 16'h0000);
            cmp(refused, 1'b0);
        end
        send(CMD_READ, 16'h0000, 1'b1);
        send(CMD_PROG, 16'h0000, 1'b0);
        send(CMD_STATUS, 16'h0000, 1'b0);
        rd();
        cmp(a.fail, 1'b0);
        wait_rdy();
        rd();
        cmp(a.fail, 1'b1);
        cmp(a.dc_rdy, 1'b1);
        cmp(a.pb_rdy, 1'b1);
        send(CMD_READ, 16'h0000, 1'b0);
        send(CMD_STATUS, 16'h0000, 1'b0);
        rd();
        cmp(a.fail, 1'b0);
        send(CMD_READ, 16'h0000, 1'b0);
        rd();
        cmp(a.data, 8'h0D);
        cmp(a.districts, 8'h08);
        send(CMD_SDIN, 16'h0003, 1'b1);
        for (k = 0; k < 3; k++) begin
            send(CMD_SDIN, 16'h0005, 1'b0);
            send(CMD_PROG, 16'h0000, 1'b0);
            wait_rdy();
        end
        send(CMD_SDIN, 16'h0005, 1'b1);
        wp_enable = 1'b0;
        send(CMD_SDIN, 16'h0006, 1'b1);
        wp_enable = 1'b1;
        send(CMD_SDIN, 16'h0006, 1'b0);
        send(CMD_CPROG, 16'h0000, 1'b0);
        wait_rdy();
        send(CMD_STATUS, 16'h0000, 1'b0);
        rd();
        cmp(a.fail, 1'b1);
        cmp(a.fail_prev, 1'b1);
        send(CMD_SDIN, 16'h0007, 1'b0);
        send(CMD_PROG, 16'h0000, 1'b0);
        send(CMD_RESET, 16'h0000, 1'b0);
        wait_rdy();
        send(CMD_STATUS, 16'h0000, 1'b0);
        rd();
        cmp(a.fail, 1'b0);
        cmp(a.fail_prev, 1'b0);
        end_sim();
    end
endmodule
